// file: hdl/boot_pins_pkg.sv
// Constants and types for the boot mode and status pin logic
// Overview of operation
// - Boot select low for five seconds from power-up enters monitor mode.
// - Boot select released before five seconds starts host auto baud detection.
// - Boot select asserted low while in tunnel mode leaves tunnel mode.
// - External reset low aborts all activity and clears internal state at once.
// - Application mode: pending flag rises on new socket data, falls on read.
// - Monitor mode: shared pin carries programming port serial transmit data.
// - Force tunnel input is unimplemented; the device ignores it.
// - Sleep inhibit input is unimplemented; the device ignores it.
package boot_pins_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MONITOR_HOLD_S = 5;
    localparam int unsigned MONITOR_HOLD_CYC_DEF = MONITOR_HOLD_S * CLK_HZ;
    localparam int unsigned HOLD_CNT_W = 27;
    typedef enum logic [1:0] {
        BOOT_MEASURE,
        BOOT_MONITOR,
        BOOT_APPLICATION
    } boot_state_e;
endpackage

// file: hdl/pin_sync.sv
// Two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Pin and synchronised level
    input wire logic pin_i,
    output logic level_o
);
    logic stage1;
    // Resets high: matches the idle level of the pulled-up pins
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stage1 <= 1'b1;
            level_o <= 1'b1;
        end else begin
            stage1 <= pin_i;
            level_o <= stage1;
        end
    end
endmodule
`default_nettype wire

// file: hdl/boot_mode_pins.sv
// Boot mode selection and shared status pin logic
`timescale 1ns/1ps
`default_nettype none
module boot_mode_pins
    import boot_pins_pkg::*;
#(
    parameter int unsigned MONITOR_HOLD_CYC = MONITOR_HOLD_CYC_DEF
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Pins from the board
    input wire logic boot_select_n_i,
    input wire logic force_tunnel_mode_n_i,
    input wire logic sleep_inhibit_i,
    // Core-side events
    input wire logic socket_data_new_i,
    input wire logic socket_data_read_i,
    input wire logic programming_serial_tx_i,
    input wire logic tunnel_mode_active_i,
    // Mode outputs
    output logic monitor_mode_o,
    output logic auto_baud_start_o,
    output logic tunnel_exit_o,
    output logic boot_done_o,
    // Shared pin
    output logic tx_or_pending_o
);
    logic sel_n;
    boot_state_e state;
    boot_state_e next_state;
    logic [HOLD_CNT_W-1:0] hold_cnt;
    logic sel_n_prev;
    logic pending;
    logic tx_q;
    logic tunnel_exit;
    logic auto_baud;
    logic sync_warm;
    logic sync_full;

    // Unimplemented strap pins are accepted and deliberately unused
    wire unused_pins = force_tunnel_mode_n_i ^ sleep_inhibit_i;

    pin_sync u_sel_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(boot_select_n_i),
        .level_o(sel_n)
    );

    // ****************************************
    // Boot hold-time measurement
    // ****************************************
    wire hold_reached = (hold_cnt >= HOLD_CNT_W'(MONITOR_HOLD_CYC - 1));
    wire sel_fall = sel_n_prev && !sel_n;
    wire sel_released = sync_full && sel_n;
    wire sel_held = sync_full && !sel_n;

    // Synchroniser shows its reset value for two edges; wait before judging
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync_warm <= 1'b0;
            sync_full <= 1'b0;
        end else begin
            sync_warm <= 1'b1;
            sync_full <= sync_warm;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            BOOT_MEASURE: begin
                if (sel_released) begin
                    next_state = BOOT_APPLICATION;
                end else if (sel_held && hold_reached) begin
                    next_state = BOOT_MONITOR;
                end
            end
            BOOT_MONITOR: next_state = BOOT_MONITOR;
            BOOT_APPLICATION: next_state = BOOT_APPLICATION;
        endcase
    end

    // Reset clears everything immediately, no clock needed
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= BOOT_MEASURE;
            hold_cnt <= '0;
            sel_n_prev <= 1'b1;
        end else begin
            state <= next_state;
            sel_n_prev <= sel_n;
            if (state == BOOT_MEASURE && sel_held && !hold_reached) begin
                hold_cnt <= hold_cnt + HOLD_CNT_W'(1);
            end
        end
    end

    // ****************************************
    // Mode pulses and pending flag
    // ****************************************
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            auto_baud <= 1'b0;
            tunnel_exit <= 1'b0;
            pending <= 1'b0;
            tx_q <= 1'b1;
        end else begin
            // Only a press that was measured and released short
            auto_baud <= (state == BOOT_MEASURE) && sel_released
                         && (hold_cnt != '0);
            tunnel_exit <= sel_fall && tunnel_mode_active_i;
            // New data wins over a read in the same cycle
            if (socket_data_new_i) begin
                pending <= 1'b1;
            end else if (socket_data_read_i) begin
                pending <= 1'b0;
            end
            tx_q <= programming_serial_tx_i;
        end
    end

    assign monitor_mode_o = (state == BOOT_MONITOR);
    assign boot_done_o = (state != BOOT_MEASURE);
    assign auto_baud_start_o = auto_baud;
    assign tunnel_exit_o = tunnel_exit;
    // Pin shows registered programming serial tx in monitor mode, else the pending flag
    assign tx_or_pending_o = monitor_mode_o ? tx_q : pending;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_held_low;
        sel_held && state == BOOT_MEASURE && hold_reached;
    endsequence
    property p_monitor_entry;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_held_low |=> monitor_mode_o;
    endproperty
    a_monitor_entry: assert property (p_monitor_entry)
        else $error("monitor mode not entered after hold");
    property p_auto_baud;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state == BOOT_MEASURE && sel_released && hold_cnt != '0)
        |=> auto_baud_start_o;
    endproperty
    a_auto_baud: assert property (p_auto_baud)
        else $error("auto baud not started on short hold");
    property p_no_monitor_early;
        @(posedge clk_i) disable iff (!arst_n_i)
        $rose(monitor_mode_o) |-> $past(hold_reached);
    endproperty
    a_no_monitor_early: assert property (p_no_monitor_early)
        else $error("monitor mode entered early");
    property p_tunnel_exit;
        @(posedge clk_i) disable iff (!arst_n_i)
        (sel_fall && tunnel_mode_active_i) |=> tunnel_exit_o;
    endproperty
    a_tunnel_exit: assert property (p_tunnel_exit)
        else $error("tunnel mode not left on select");
    property p_pending_set;
        @(posedge clk_i) disable iff (!arst_n_i)
        (socket_data_new_i && !monitor_mode_o && !$rose(monitor_mode_o))
        |=> (tx_or_pending_o || monitor_mode_o);
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("pending flag not raised");
    property p_pending_clr;
        @(posedge clk_i) disable iff (!arst_n_i)
        (socket_data_read_i && !socket_data_new_i && !monitor_mode_o)
        |=> !tx_or_pending_o;
    endproperty
    a_pending_clr: assert property (p_pending_clr)
        else $error("pending flag not lowered on read");
    property p_monitor_tx;
        @(posedge clk_i) disable iff (!arst_n_i)
        monitor_mode_o ##1 monitor_mode_o
        |-> tx_or_pending_o == $past(programming_serial_tx_i);
    endproperty
    a_monitor_tx: assert property (p_monitor_tx)
        else $error("shared pin not carrying programming tx");
    property p_count_grows;
        @(posedge clk_i) disable iff (!arst_n_i)
        (state == BOOT_MEASURE && sel_held && !hold_reached)
        |=> hold_cnt == $past(hold_cnt) + HOLD_CNT_W'(1);
    endproperty
    a_count_grows: assert property (p_count_grows)
        else $error("hold counter not counting");
    property p_wait_for_sync;
        @(posedge clk_i) disable iff (!arst_n_i)
        !sync_full |=> !boot_done_o;
    endproperty
    a_wait_for_sync: assert property (p_wait_for_sync)
        else $error("mode chosen before select was synchronised");
    property p_auto_baud_once;
        @(posedge clk_i) disable iff (!arst_n_i)
        auto_baud_start_o |=> !auto_baud_start_o;
    endproperty
    a_auto_baud_once: assert property (p_auto_baud_once)
        else $error("auto baud pulse longer than one cycle");
    property p_exit_gated;
        @(posedge clk_i) disable iff (!arst_n_i)
        !tunnel_mode_active_i |=> !tunnel_exit_o;
    endproperty
    a_exit_gated: assert property (p_exit_gated)
        else $error("tunnel exit outside tunnel mode");
    property p_mode_kept;
        @(posedge clk_i) disable iff (!arst_n_i)
        boot_done_o |=> boot_done_o && $stable(monitor_mode_o);
    endproperty
    a_mode_kept: assert property (p_mode_kept)
        else $error("boot mode changed after decision");
    sequence s_app_quiet;
        !monitor_mode_o && !socket_data_new_i && !socket_data_read_i;
    endsequence
    property p_pending_hold;
        @(posedge clk_i) disable iff (!arst_n_i)
        s_app_quiet ##1 !monitor_mode_o |-> $stable(tx_or_pending_o);
    endproperty
    a_pending_hold: assert property (p_pending_hold)
        else $error("pending flag changed without an event");
endmodule
`default_nettype wire

// file: dv/strap_model.sv
// Board strap model driving the boot select pin
`timescale 1ns/1ps
`default_nettype none
module strap_model (
    // Clock and command
    input wire logic clk_i,
    input wire logic start_i,
    input wire logic [15:0] low_cyc_i,
    // Strap pin
    output logic boot_select_n_o
);
    logic [15:0] left = 16'h0;
    // Released pin floats high through its pull-up
    assign boot_select_n_o = (left == 16'h0);
    always @(negedge clk_i) begin
        if (start_i) begin
            left <= low_cyc_i;
        end else if (left != 16'h0) begin
            left <= left - 16'h1;
        end
    end
endmodule
`default_nettype wire

// file: dv/boot_mode_pins_tb.sv
// Self-checking bench for the boot mode and status pin logic
`timescale 1ns/1ps
`default_nettype none
module boot_mode_pins_tb;
    logic clk_i = 1'b0, arst_n = 1'b0, start = 1'b0, sel_n, ftm_n = 1'b1;
    logic slp = 1'b0, s_new = 1'b0, s_read = 1'b0, ptx = 1'b0, tun = 1'b0;
    logic mon, abd, tex, done, pin, prev_done = 1'b0, b = 1'b0;
    logic [15:0] low_cyc = 16'h0;
    logic [1:0] exp_q[$];
    logic [2:0] pend_tab [5] = '{3'h5, 3'h1, 3'h2, 3'h7, 3'h2};
    int n_fail = 0, cmp_count = 0;
    boot_mode_pins #(.MONITOR_HOLD_CYC(50)) boot_mode_pins_inst (
        .clk_i(clk_i), .arst_n_i(arst_n), .boot_select_n_i(sel_n),
        .force_tunnel_mode_n_i(ftm_n), .sleep_inhibit_i(slp),
        .socket_data_new_i(s_new), .socket_data_read_i(s_read),
        .programming_serial_tx_i(ptx), .tunnel_mode_active_i(tun),
        .monitor_mode_o(mon), .auto_baud_start_o(abd),
        .tunnel_exit_o(tex), .boot_done_o(done), .tx_or_pending_o(pin));
    strap_model strap_model_inst (.clk_i(clk_i), .start_i(start),
        .low_cyc_i(low_cyc), .boot_select_n_o(sel_n));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // ********************************
    // Checking and bounded waits
    // ********************************
    task automatic close_out();
        if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic note(input logic [1:0] got);
        if (exp_q.size() == 0) check(1'b0, "unexpected event");
        else check(exp_q.pop_front() === got, "event mismatch");
    endtask
    task automatic drain(input int lim);
        for (int i = 0; i < lim && exp_q.size() != 0; i++) @(negedge clk_i);
        if (exp_q.size() != 0) begin
            check(1'b0, "expected event missing");
            close_out();
        end
        repeat (4) @(negedge clk_i);
    endtask
    task automatic strap(input logic [15:0] lc);
        start <= 1'b1;
        low_cyc <= lc;
        @(negedge clk_i);
        start <= 1'b0;
    endtask
    task automatic boot(input logic [15:0] lc);
        @(negedge clk_i);
        arst_n <= 1'b0;
        strap(lc);
        repeat (4) @(negedge clk_i);
        arst_n <= 1'b1;
    endtask
    // Mode events are logged in order: done, auto baud, tunnel exit
    always @(negedge clk_i) begin
        if (arst_n === 1'b1) begin
            if (done === 1'b1 && prev_done !== 1'b1) note({1'b0, mon});
            if (abd === 1'b1) note(2'h2);
            if (tex === 1'b1) note(2'h3);
        end
        prev_done <= done;
        ftm_n <= 1'($urandom);
        slp <= 1'($urandom);
    end
    // ********************************
    // Scenarios
    // ********************************
    initial begin
        void'($urandom(32'hf506));
        exp_q.push_back(2'h1);
        boot(16'd80);
        drain(200);
        for (int i = 0; i < 16; i++) begin
            @(negedge clk_i);
            if (i > 0) check(pin === b, "tx copy");
            b = 1'($urandom);
            ptx <= b;
            s_new <= 1'($urandom);
            s_read <= 1'($urandom);
            tun <= 1'($urandom);
        end
        s_new <= 1'b0;
        s_read <= 1'b0;
        tun <= 1'b0;
        arst_n = 1'b0;
        #1;
        check({mon, abd, tex, done, pin} === 5'h0, "reset");
        exp_q.push_back(2'h0);
        exp_q.push_back(2'h2);
        // Random short press, always released before the hold ends
        boot(16'd8 + 16'($urandom % 33));
        drain(200);
        exp_q.push_back(2'h0);
        boot(16'd0);
        drain(200);
        for (int i = 0; i < 5; i++) begin
            @(negedge clk_i);
            s_new <= pend_tab[i][2];
            s_read <= pend_tab[i][1];
            @(negedge clk_i);
            s_new <= 1'b0;
            s_read <= 1'b0;
            check(pin === pend_tab[i][0], "pending flag");
        end
        // Select pulse outside tunnel mode must stay silent
        strap(16'd2 + 16'($urandom % 6));
        repeat (10) @(negedge clk_i);
        tun <= 1'b1;
        exp_q.push_back(2'h3);
        strap(16'd4);
        drain(20);
        close_out();
    end
endmodule
`default_nettype wire
